/* File: hw/hsi_debounce.sv */
module hsi_debounce
  import hsi_pkg::*;
#(
  parameter int STABLE_MS = DEBOUNCE_MS
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // millisecond tick
  input  wire logic ms_tick_i,
  // raw and filtered level
  input  wire logic raw_i,
  output logic      level_o
);

  localparam int CW = $clog2(STABLE_MS + 1);

  logic [CW-1:0] cnt;

  // ---------------------------------------------------------------
  // stability counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt     <= '0;
      level_o <= 1'b0;
    end else if (raw_i == level_o) begin
      cnt <= '0;
    end else if (ms_tick_i) begin
      if (cnt == CW'(STABLE_MS - 1)) begin
        cnt     <= '0;
        level_o <= raw_i;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

endmodule : hsi_debounce

/* File: hw/hsi_indicator.sv */
// Local design decisions: the APB register port and the register addresses.
module hsi_indicator
  import hsi_pkg::*;
#(
  parameter int MS_CYCLES   = CYCLES_PER_MS,
  parameter int FLASH_CYC   = FLASH_CYCLES,
  parameter int HOLD_TIME   = HOLD_MS,
  parameter int DB_MS       = DEBOUNCE_MS,
  parameter int BLINK_MS    = TRACK_BLINK_MS
) (
  // clock and reset
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  // apb slave
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [7:0]    PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  output logic               IRQ_O,
  // user side
  input  wire logic          INQUIRY_BUTTON_I,
  input  wire logic          TRANSDUCER_PRESENT_I,
  input  wire logic [3:0]    SELECTOR_BANK_A_I,
  input  wire logic [3:0]    SELECTOR_BANK_B_I,
  input  wire logic [3:0]    SELECTOR_BANK_C_I,
  // processor side
  input  wire hsi_conv_type  CONV_STATE_I,
  input  wire logic          TARGET_TRACK_REQ_I,
  output logic               TRACK_REQ_O,
  output logic               OUTPUT_EN_O,
  output logic [2:0]         INPUT_PATH_O,
  // indicators
  output logic               LED_TRACK_O,
  output logic               LED_CAP_O,
  output logic               LED_BATT_O
);

  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam int FW = $clog2(FLASH_CYC + 1);
  localparam int HW = $clog2(HOLD_TIME + 1);
  localparam int BW = $clog2(BLINK_MS + 1);

  logic [MW-1:0]    ms_cnt;
  logic             ms_tick;
  logic             btn_db;
  logic             btn_prev;
  logic             press;
  logic [HW-1:0]    hold_cnt;
  logic             hold_done;
  logic             connected;
  logic             present_prev;
  logic [3:0]       bank_a_prev;
  hsi_conv_type     state_prev;
  logic             entry;
  logic             seq_done;
  logic [BW-1:0]    blink_cnt;
  logic             blink;
  logic             force_track;
  logic [FW-1:0]    flash_cnt;
  logic [2:0]       led;
  logic [2:0]       next_led;
  logic             next_flash;
  logic [1:0]       ctrl;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_event;
  logic             wr_ok;
  logic [31:0]      status_word;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ---------------------------------------------------------------
  // millisecond timebase and button filter
  // ---------------------------------------------------------------
  // millisecond tick
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == MW'(MS_CYCLES - 1));
      if (ms_cnt == MW'(MS_CYCLES - 1))
        ms_cnt <= '0;
      else
        ms_cnt <= ms_cnt + MW'(1);
    end
  end
  hsi_debounce #(
    .STABLE_MS (DB_MS)
  ) u_debounce (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .ms_tick_i (ms_tick),
    .raw_i     (INQUIRY_BUTTON_I),
    .level_o   (btn_db)
  );

  assign press = btn_db && !btn_prev;

  // ---------------------------------------------------------------
  // hold timing and output connection
  // ---------------------------------------------------------------
  // ten second hold
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      btn_prev  <= 1'b0;
      hold_cnt  <= '0;
      hold_done <= 1'b0;
    end else begin
      btn_prev  <= btn_db;
      hold_done <= 1'b0;
      if (!btn_db)
        hold_cnt <= '0;
      else if (ms_tick && hold_cnt != HW'(HOLD_TIME)) begin
        hold_cnt  <= hold_cnt + HW'(1);
        hold_done <= (hold_cnt == HW'(HOLD_TIME - 1));
      end
    end
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      connected   <= 1'b1;
      OUTPUT_EN_O <= 1'b0;
    end else begin
      if (hold_done)
        connected <= !connected;
      OUTPUT_EN_O <= connected && !btn_db;
    end
  end

  // ---------------------------------------------------------------
  // tracking requests and state entry
  // ---------------------------------------------------------------
  assign entry    = CONV_STATE_I != state_prev;
  assign seq_done = entry && state_prev == CONV_BATT &&
                    CONV_STATE_I == CONV_NORMAL;
  assign blink    = ms_tick && CONV_STATE_I == CONV_TRACK &&
                    blink_cnt == BW'(BLINK_MS - 1);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      present_prev <= 1'b0;
      bank_a_prev  <= BANK_ALL_OFF;
      state_prev   <= CONV_TRACK;
      blink_cnt    <= '0;
      TRACK_REQ_O  <= 1'b0;
      INPUT_PATH_O <= PATH_NONE;
    end else begin
      present_prev <= TRANSDUCER_PRESENT_I;
      bank_a_prev  <= SELECTOR_BANK_A_I;
      state_prev   <= CONV_STATE_I;
      if (CONV_STATE_I != CONV_TRACK || blink)
        blink_cnt <= '0;
      else if (ms_tick)
        blink_cnt <= blink_cnt + BW'(1);
      TRACK_REQ_O <= force_track;
      INPUT_PATH_O <= hsi_path(SELECTOR_BANK_A_I, SELECTOR_BANK_B_I,
                               SELECTOR_BANK_C_I);
    end
  end
  assign force_track = (TRANSDUCER_PRESENT_I && !present_prev && btn_db)
                    || TARGET_TRACK_REQ_I
                    || (SELECTOR_BANK_A_I != bank_a_prev)
                    || (wr_ok && PADDR_I == ADDR_CTRL &&
                        PWDATA_I[CTRL_FORCE_BIT]);

  // ---------------------------------------------------------------
  // led flash selection
  // ---------------------------------------------------------------
  // report state on press, or the output connection when in the normal state
  always_comb begin
    next_flash = 1'b1;
    next_led   = LED_NONE;
    if (hold_done)
      next_led = hsi_conn_led(!connected);
    else if (press && CONV_STATE_I == CONV_NORMAL)
      next_led = hsi_conn_led(connected);
    else if (press)
      next_led = hsi_state_led(CONV_STATE_I);
    else if (seq_done)
      next_led = LED_ALL;
    else if (entry && CONV_STATE_I != CONV_NORMAL)
      next_led = hsi_state_led(CONV_STATE_I);
    else if (blink)
      next_led = 3'h1;
    else
      next_flash = 1'b0;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flash_cnt   <= '0;
      led         <= LED_NONE;
      LED_TRACK_O <= 1'b0;
      LED_CAP_O   <= 1'b0;
      LED_BATT_O  <= 1'b0;
    end else begin
      if (next_flash) begin
        led       <= next_led;
        flash_cnt <= FW'(FLASH_CYC - 1);
      end else if (flash_cnt != '0)
        flash_cnt <= flash_cnt - FW'(1);
      else
        led <= LED_NONE;
      LED_TRACK_O <= next_flash ? next_led[LED_TRACK] : led[LED_TRACK]
                     && (flash_cnt != '0) && ctrl[CTRL_LED_EN_BIT];
      LED_CAP_O   <= next_flash ? next_led[LED_CAP] : led[LED_CAP]
                     && (flash_cnt != '0) && ctrl[CTRL_LED_EN_BIT];
      LED_BATT_O  <= next_flash ? next_led[LED_BATT] : led[LED_BATT]
                     && (flash_cnt != '0) && ctrl[CTRL_LED_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // apb registers and interrupt
  // ---------------------------------------------------------------
  assign wr_ok = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign int_event = {force_track, seq_done, entry, hold_done, press};
  assign status_word = {22'h000000, led,
                        INPUT_PATH_O, btn_db, connected,
                        CONV_STATE_I};

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl     <= CTRL_RESET;
      int_mask <= INT_MASK_RESET;
    end else if (wr_ok) begin
      if (PADDR_I == ADDR_CTRL)
        ctrl <= {PWDATA_I[CTRL_LED_EN_BIT], 1'b0};
      if (PADDR_I == ADDR_INT_MASK)
        int_mask <= PWDATA_I[INT_W-1:0];
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      int_status <= '0;
      IRQ_O      <= 1'b0;
    end else begin
      if (wr_ok && PADDR_I == ADDR_INT_STATUS)
        int_status <= (int_status & ~PWDATA_I[INT_W-1:0]) | int_event;
      else
        int_status <= int_status | int_event;
      IRQ_O <= |(int_status & int_mask);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      if (PSEL_I && PENABLE_I && !PREADY_O) begin
        case (PADDR_I)
          ADDR_CTRL:       PRDATA_O <= {30'h00000000, ctrl};
          ADDR_STATUS:     PRDATA_O <= status_word;
          ADDR_INT_STATUS: PRDATA_O <= {27'h0000000, int_status};
          ADDR_INT_MASK:   PRDATA_O <= {27'h0000000, int_mask};
          default:         PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // power cut when held
  property p_no_power_held;
    btn_db |=> !OUTPUT_EN_O;
  endproperty
  a_no_power_held: assert property (p_no_power_held)
    else $error("output powered while button held");

  property p_disconnect;
    (hold_done && connected) |=> !connected &&
      {LED_BATT_O, LED_CAP_O, LED_TRACK_O} == LED_CHARGE ##1 !OUTPUT_EN_O;
  endproperty
  a_disconnect: assert property (p_disconnect)
    else $error("hold did not disconnect output");

  property p_reconnect;
    (hold_done && !connected) |=> connected &&
      {LED_BATT_O, LED_CAP_O, LED_TRACK_O} == LED_ALL;
  endproperty
  a_reconnect: assert property (p_reconnect)
    else $error("hold did not reconnect output");

  property p_bank_track;
    (SELECTOR_BANK_A_I != $past(SELECTOR_BANK_A_I)) |=> TRACK_REQ_O;
  endproperty
  a_bank_track: assert property (p_bank_track)
    else $error("bank a change gave no tracking request");

  property p_path_pv;
    (SELECTOR_BANK_C_I == BANK_ALL_ON && SELECTOR_BANK_B_I == BANK_ALL_OFF
     && SELECTOR_BANK_A_I == BANK_ALL_OFF) |=> INPUT_PATH_O == PATH_PV;
  endproperty
  a_path_pv: assert property (p_path_pv)
    else $error("photovoltaic path not selected");

  property p_path_piezo;
    (SELECTOR_BANK_C_I == BANK_ALL_OFF && SELECTOR_BANK_B_I == BANK_ALL_ON
     && SELECTOR_BANK_A_I == BANK_A_PIEZO) |=> INPUT_PATH_O == PATH_PIEZO;
  endproperty
  a_path_piezo: assert property (p_path_piezo)
    else $error("piezoelectric path not selected");

  property p_seq_flash;
    (seq_done && !hold_done && !press && ctrl[CTRL_LED_EN_BIT])
      |=> {LED_BATT_O, LED_CAP_O, LED_TRACK_O} == LED_ALL;
  endproperty
  a_seq_flash: assert property (p_seq_flash)
    else $error("sequence complete did not flash all leds");

  property p_flash_end;
    (flash_cnt == FW'(1) && !next_flash) ##1 !next_flash |=> !LED_TRACK_O;
  endproperty
  a_flash_end: assert property (p_flash_end)
    else $error("tracking led flash too long");

endmodule : hsi_indicator

/* File: hw/hsi_pkg.sv */
package hsi_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYCLES_PER_MS  = CLK_HZ / MS_PER_S;
  localparam int FLASH_MS       = 1;
  localparam int FLASH_CYCLES   = FLASH_MS * CYCLES_PER_MS;
  localparam int HOLD_S         = 10;
  localparam int HOLD_MS        = HOLD_S * MS_PER_S;
  localparam int DEBOUNCE_MS    = 20;
  localparam int TRACK_BLINK_MS = 500;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_INT_MASK   = 8'h0C;
  localparam int          CTRL_FORCE_BIT  = 0;
  localparam int          CTRL_LED_EN_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h2;
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_CONN_BIT     = 2;
  localparam int          ST_BUTTON_BIT   = 3;
  localparam int          ST_PATH_LSB     = 4;
  localparam int          ST_LED_LSB      = 7;
  localparam int          INT_W           = 5;
  localparam int          INT_PRESS       = 0;
  localparam int          INT_TOGGLE      = 1;
  localparam int          INT_ENTRY       = 2;
  localparam int          INT_SEQ         = 3;
  localparam int          INT_TRACK       = 4;
  localparam logic [4:0]  INT_MASK_RESET  = 5'h00;

  // ---------------------------------------------------------------
  // leds, banks and input paths
  // ---------------------------------------------------------------
  localparam int          LED_TRACK    = 0;
  localparam int          LED_CAP      = 1;
  localparam int          LED_BATT     = 2;
  localparam logic [2:0]  LED_ALL      = 3'h7;
  localparam logic [2:0]  LED_CHARGE   = 3'h6;
  localparam logic [2:0]  LED_NONE     = 3'h0;
  localparam logic [3:0]  BANK_ALL_ON  = 4'hF;
  localparam logic [3:0]  BANK_ALL_OFF = 4'h0;
  localparam logic [3:0]  BANK_C_TEG   = 4'h7;
  localparam logic [3:0]  BANK_A_TEG   = 4'h4;
  localparam logic [3:0]  BANK_A_EM    = 4'hC;
  localparam logic [3:0]  BANK_A_PIEZO = 4'h8;
  localparam logic [2:0]  PATH_NONE    = 3'h0;
  localparam logic [2:0]  PATH_PV      = 3'h1;
  localparam logic [2:0]  PATH_TEG     = 3'h2;
  localparam logic [2:0]  PATH_EM      = 3'h3;
  localparam logic [2:0]  PATH_PIEZO   = 3'h4;

  typedef enum logic [1:0] {
    CONV_TRACK,
    CONV_CAP,
    CONV_BATT,
    CONV_NORMAL
  } hsi_conv_type;

  function automatic logic [2:0] hsi_state_led(input hsi_conv_type s);
    case (s)
      CONV_TRACK: hsi_state_led = 3'h1;
      CONV_CAP:   hsi_state_led = 3'h2;
      CONV_BATT:  hsi_state_led = 3'h4;
      default:    hsi_state_led = LED_ALL;
    endcase
  endfunction : hsi_state_led

  function automatic logic [2:0] hsi_conn_led(input logic conn);
    hsi_conn_led = conn ? LED_ALL : LED_CHARGE;
  endfunction : hsi_conn_led

  function automatic logic [2:0] hsi_path(input logic [3:0] a,
                                          input logic [3:0] b,
                                          input logic [3:0] c);
    hsi_path = PATH_NONE;
    if (c == BANK_ALL_ON && b == BANK_ALL_OFF && a == BANK_ALL_OFF)
      hsi_path = PATH_PV;
    else if (c == BANK_C_TEG && b == BANK_ALL_OFF && a == BANK_A_TEG)
      hsi_path = PATH_TEG;
    else if (c == BANK_ALL_ON && b == BANK_ALL_OFF && a == BANK_A_EM)
      hsi_path = PATH_EM;
    else if (c == BANK_ALL_OFF && b == BANK_ALL_ON && a == BANK_A_PIEZO)
      hsi_path = PATH_PIEZO;
  endfunction : hsi_path

endpackage : hsi_pkg

/* File: tb/hsi_user_model.sv */
module hsi_user_model
  import hsi_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // indicator seen by the user
  input  wire logic       led_track_i,
  // user controls and target link
  output logic            button_o,
  output logic            present_o,
  output logic [3:0]      bank_a_o,
  output logic [3:0]      bank_b_o,
  output logic [3:0]      bank_c_o,
  output logic            target_req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    button_o     = 1'b0;
    present_o    = 1'b1;
    bank_a_o     = 4'h0;
    bank_b_o     = 4'h0;
    bank_c_o     = 4'hF;
    target_req_o = 1'b0;
  end

  task automatic hold(input int cyc);
    @(posedge clk_i) button_o <= 1'b1;
    repeat (cyc) @(posedge clk_i);
    button_o <= 1'b0;
  endtask : hold

  // one transducer setting at a time
  task automatic set_banks(input logic [3:0] a, b, c);
    @(posedge clk_i);
    bank_a_o <= a;
    bank_b_o <= b;
    bank_c_o <= c;
  endtask : set_banks

  // one request from the target link
  task automatic target_pulse();
    @(posedge clk_i) target_req_o <= !target_req_o;
    @(posedge clk_i) target_req_o <= !target_req_o;
  endtask : target_pulse

  // attach with button held, release on tracking flash
  task automatic force_attach(input int lim);
    int n;
    n = 0;
    @(posedge clk_i) present_o <= 1'b0;
    button_o <= 1'b1;
    repeat (40) @(posedge clk_i);
    present_o <= 1'b1;
    while (led_track_i !== 1'b0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    while (led_track_i !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    button_o <= 1'b0;
  endtask : force_attach
endmodule : hsi_user_model

/* File: tb/tb_top.sv */
module tb_top;
  import hsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic btn, present, treq, track_req, out_en, l_tr, l_cap, l_bat;
  logic [3:0] ba, bb, bc;
  logic [2:0] path, leds;
  hsi_conv_type conv;
  int fail_count, total_checks, track_cnt, c0;
  logic [31:0] rd;
  logic err;

  assign leds = {l_bat, l_cap, l_tr};

  hsi_indicator #(.MS_CYCLES(10), .FLASH_CYC(10), .HOLD_TIME(20),
    .DB_MS(2), .BLINK_MS(4)) dut_u (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_O(irq), .INQUIRY_BUTTON_I(btn), .TRANSDUCER_PRESENT_I(present),
    .SELECTOR_BANK_A_I(ba), .SELECTOR_BANK_B_I(bb),
    .SELECTOR_BANK_C_I(bc), .CONV_STATE_I(conv),
    .TARGET_TRACK_REQ_I(treq), .TRACK_REQ_O(track_req),
    .OUTPUT_EN_O(out_en), .INPUT_PATH_O(path), .LED_TRACK_O(l_tr),
    .LED_CAP_O(l_cap), .LED_BATT_O(l_bat));

  hsi_user_model user_u (.clk_i(clk), .led_track_i(l_tr), .button_o(btn),
    .present_o(present), .bank_a_o(ba), .bank_b_o(bb), .bank_c_o(bc),
    .target_req_o(treq));

  // ---------------------------------------------------------------
  // clock, reset, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  always @(posedge clk) begin
    if (track_req === 1'b1) track_cnt++;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_conv(input hsi_conv_type s);
    while (leds !== 3'h0) @(negedge clk);
    @(posedge clk) conv <= s;
  endtask : set_conv

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic wait_led(input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    while (leds !== 3'h0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    while (leds === 3'h0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({29'h0, leds}, {29'h0, exp});
  endtask : wait_led

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  logic [3:0] ta[5] = '{4'h4, 4'hC, 4'h8, 4'h1, 4'h0};
  logic [3:0] tb_[5] = '{4'h0, 4'h0, 4'hF, 4'h0, 4'h0};
  logic [3:0] tc[5] = '{4'h7, 4'hF, 4'h0, 4'hF, 4'hF};
  logic [2:0] tp[5] = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h1};

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; conv = CONV_NORMAL;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h00, 32'h2);
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h04, 32'h17);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      c0 = track_cnt;
      user_u.set_banks(ta[i], tb_[i], tc[i]);
      repeat (4) @(posedge clk);
      chk({29'h0, path}, {29'h0, tp[i]});
      chk(track_cnt - c0, 1);
    end
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h08, 32'h1F);
    apb(1'b1, 8'h0C, 32'h1);
    fork
      user_u.hold(40);
      begin
        wait_led(LED_ALL, 100);
        chk({31'h0, out_en}, 32'h0);
      end
    join
    repeat (40) @(posedge clk);
    chk({31'h0, out_en}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    fork
      user_u.hold(300);
      begin
        wait_led(LED_ALL, 100);
        wait_led(LED_CHARGE, 400);
      end
    join
    repeat (40) @(posedge clk);
    chk({31'h0, out_en}, 32'h0);
    fork
      user_u.hold(300);
      begin
        wait_led(LED_CHARGE, 100);
        wait_led(LED_ALL, 400);
      end
    join
    repeat (40) @(posedge clk);
    chk({31'h0, out_en}, 32'h1);
    set_conv(CONV_CAP);
    wait_led(3'h2, 50);
    fork
      user_u.hold(40);
      wait_led(3'h2, 100);
    join
    set_conv(CONV_BATT);
    wait_led(3'h4, 50);
    set_conv(CONV_NORMAL);
    wait_led(LED_ALL, 50);
    set_conv(CONV_TRACK);
    wait_led(3'h1, 50);
    wait_led(3'h1, 200);
    c0 = track_cnt;
    user_u.target_pulse();
    repeat (3) @(posedge clk);
    chk(track_cnt - c0, 1);
    apb(1'b1, 8'h00, 32'h3);
    repeat (3) @(posedge clk);
    chk(track_cnt - c0, 2);
    rd_chk(8'h00, 32'h2);
    user_u.force_attach(200);
    chk(track_cnt - c0, 3);
    set_conv(CONV_NORMAL);
    repeat (10) @(posedge clk);
    wrap_up();
  end
endmodule : tb_top
